// File: asm_fifo.sv
// Summary of operation
// - transmit only as reply to a command, or the test byte in test mode
// - answer only when command site number matches
// - bus driver enabled from first start bit to last stop bit, held across gaps
// - one pair, talk and listen never together outside test mode
// - same transmit data on both ports
// - receive lines merged by or of space
// - no handshake lines
// - test mode sends test byte periodically
`timescale 1ns/1ps

package asm_pkg;
    localparam int CLK_HZ          = 200_000_000;
    localparam int CLK_PERIOD_NS   = 5;
    localparam int BAUD_RATE       = 9600;
    localparam int OVERSAMPLE      = 16;
    localparam int BAUD16_DIV      = CLK_HZ / (BAUD_RATE * OVERSAMPLE);
    localparam int TEST_PERIOD_MS  = 1000;
    localparam int TEST_PERIOD_CYC = (CLK_HZ / 1000) * TEST_PERIOD_MS;
    localparam int FRAME_BITS      = 10;
    localparam int FIFO_DEPTH      = 4;
    localparam logic [3:0] BIT_MID  = 4'h7;
    localparam logic [3:0] STOP_IDX = 4'h9;
    localparam logic [7:0] TEST_BYTE = 8'h55;
    localparam logic [1:0] SYNC_RST  = 2'h3;

    // one reply character and its end-of-reply mark
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } asm_reply_type;

    // a command that passed the site check
    typedef struct packed {
        logic [7:0] site;
        logic [7:0] code;
    } asm_cmd_type;

    typedef enum {
        ST_LISTEN,
        ST_SKIP,
        ST_CODE,
        ST_REPLY
    } asm_state_type;
endpackage : asm_pkg

// small synchronous fifo, count based so depth need not be a power of two
module asm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  logic             mclk,
    input  logic             rstn,
    // filling side
    input  logic             inValid,
    output logic             inReady,
    input  logic [WIDTH-1:0] inData,
    // draining side
    output logic             outValid,
    input  logic             outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
            $error("fifo needs depth of two or more");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_q;
    logic [PW-1:0]    rdPtr_q;
    logic [CW-1:0]    count_q;
    logic             push;
    logic             pop;

    // flags straight from the count, so full and empty are exact
    assign inReady  = (count_q != FULL_CNT);
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // storage has no reset, only the pointers matter
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // pointers and occupancy
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : PW'(wrPtr_q + 1'b1);
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : PW'(rdPtr_q + 1'b1);
            end
            if (push && !pop) begin
                count_q <= CW'(count_q + 1'b1);
            end else if (pop && !push) begin
                count_q <= CW'(count_q - 1'b1);
            end
        end
    end

    a_fifo_fill: assert property (@(posedge mclk) disable iff (!rstn)
        push && !pop |=> count_q == CW'($past(count_q) + 1'b1))
        else $error("fifo count did not rise on push");
    c_fifo_full: cover property (@(posedge mclk) disable iff (!rstn)
        !inReady && inValid);
endmodule : asm_fifo

// File: asm_uart_tx.sv
`timescale 1ns/1ps

// one start bit, eight data bits lsb first, one stop bit
module asm_uart_tx #(
    parameter int FRAME_BITS = 10,
    parameter int OSR        = 16
) (
    // clock and reset
    input  logic       mclk,
    input  logic       rstn,
    input  logic       tick16,
    // character request
    input  logic       startValid,
    output logic       startReady,
    input  logic [7:0] startData,
    // serial line
    output logic       txd,
    output logic       done
);
    localparam logic [3:0] PH_LAST  = 4'(OSR - 1);
    localparam logic [3:0] BIT_LAST = 4'(FRAME_BITS - 1);

    generate
        if (FRAME_BITS != 10 || OSR < 2 || OSR > 16) begin : g_bad_param
            $error("transmitter serves 8N1 with oversampling up to 16");
        end
    endgenerate

    logic       busy_q;
    logic [3:0] ph_q;
    logic [3:0] bit_q;
    logic [9:0] sh_q;
    logic       done_q;

    assign startReady = !busy_q;
    assign txd        = sh_q[0];
    assign done       = done_q;

    // shifter refills with ones, so the idle line is mark
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            busy_q <= 1'b0;
            ph_q   <= 4'h0;
            bit_q  <= 4'h0;
            sh_q   <= 10'h3FF;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (startValid && !busy_q) begin
                busy_q <= 1'b1;
                ph_q   <= 4'h0;
                bit_q  <= 4'h0;
                sh_q   <= {1'b1, startData, 1'b0};
            end else if (busy_q && tick16) begin
                ph_q <= 4'(ph_q + 4'h1);
                if (ph_q == PH_LAST) begin
                    sh_q  <= {1'b1, sh_q[9:1]};
                    bit_q <= 4'(bit_q + 4'h1);
                    if (bit_q == BIT_LAST) begin
                        busy_q <= 1'b0; // stop bit fully out
                        done_q <= 1'b1;
                    end
                end
            end
        end
    end

    a_tx_start_bit: assert property (@(posedge mclk) disable iff (!rstn)
        startValid && startReady |=> !txd && busy_q)
        else $error("start bit not driven after request");
endmodule : asm_uart_tx

// File: asm_monitor_port.sv
`timescale 1ns/1ps

module asm_monitor_port #(
    parameter int BAUD16_DIV_P  = asm_pkg::BAUD16_DIV,
    parameter int TEST_PERIOD_P = asm_pkg::TEST_PERIOD_CYC,
    parameter int FIFO_DEPTH_P  = asm_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  logic                   mclk,
    input  logic                   rstn,
    // unbalanced port, data lines only
    input  logic                   rs232Rx,
    output logic                   rs232Tx,
    // balanced bus pair
    input  logic                   rs485RxIn,
    output logic                   rs485TxOut,
    output logic                   rs485TxOe,
    // configuration
    input  logic [7:0]             siteNumber,
    input  logic                   testMode,
    // accepted command
    output logic                   cmdValid,
    output asm_pkg::asm_cmd_type   cmd,
    // reply stream
    input  logic                   replyValid,
    output logic                   replyReady,
    input  asm_pkg::asm_reply_type reply,
    // status
    output logic                   replyOpen,
    output logic                   frameError,
    output logic                   loopOk
);
    import asm_pkg::*;

    localparam logic [15:0] BDIV_M1 = 16'(BAUD16_DIV_P - 1);
    localparam logic [31:0] TPER_M1 = 32'(TEST_PERIOD_P - 1);

    generate
        if (BAUD16_DIV_P < 1 || BAUD16_DIV_P > 65536 || TEST_PERIOD_P < 1)
        begin : g_bad_param
            $error("divider or test period out of range");
        end
    endgenerate

    logic [1:0]    sync232_q, sync485_q;
    logic          rxLine, tick16, rxEn;
    logic [15:0]   baudCnt_q;
    logic          rxBusy_q, rxStb_q, rxErr_q;
    logic [3:0]    rxPh_q, rxBit_q;
    logic [7:0]    rxSh_q, siteSeen_q, txData;
    asm_state_type state_q;
    logic          cmdValid_q, lastIn_q, acceptOpen;
    asm_cmd_type   cmd_q;
    logic          fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
    asm_reply_type fifoOut;
    logic [31:0]   testCnt_q;
    logic          testPend_q, testTake, fifoTake, txStart, txReady;
    logic          txd, txDone, curLast_q, txSession_q, loopOk_q;

    // two flops per pin before anything looks at the level
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sync232_q <= SYNC_RST;
            sync485_q <= SYNC_RST;
        end else begin
            sync232_q <= {sync232_q[0], rs232Rx};
            sync485_q <= {sync485_q[0], rs485RxIn};
        end
    end

    // space on either port is space on the merged line;
    // an unused port must idle at mark or it masks the other
    assign rxLine = ~(~sync232_q[1] | ~sync485_q[1]);

    // sixteen ticks per bit time
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            baudCnt_q <= 16'h0000;
        end else if (baudCnt_q == BDIV_M1) begin
            baudCnt_q <= 16'h0000;
        end else begin
            baudCnt_q <= 16'(baudCnt_q + 16'h0001);
        end
    end
    assign tick16 = (baudCnt_q == BDIV_M1);

    // receiver deaf during own reply; loopback test keeps it open
    assign rxEn = testMode || (state_q != ST_REPLY && !txSession_q);

    // oversampling receiver, one sample at mid bit
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rxBusy_q <= 1'b0;
            rxPh_q   <= 4'h0;
            rxBit_q  <= 4'h0;
            rxSh_q   <= 8'h00;
            rxStb_q  <= 1'b0;
            rxErr_q  <= 1'b0;
        end else begin
            rxStb_q <= 1'b0;
            rxErr_q <= 1'b0;
            if (!rxEn) begin
                rxBusy_q <= 1'b0;
            end else if (tick16) begin
                if (!rxBusy_q) begin
                    if (!rxLine) begin
                        rxBusy_q <= 1'b1;
                        rxPh_q   <= 4'h0;
                        rxBit_q  <= 4'h0;
                    end
                end else begin
                    rxPh_q <= 4'(rxPh_q + 4'h1);
                    if (rxPh_q == BIT_MID) begin
                        rxBit_q <= 4'(rxBit_q + 4'h1);
                        if (rxBit_q == 4'h0) begin
                            // short glitch, not a start bit
                            if (rxLine) begin
                                rxBusy_q <= 1'b0;
                            end
                        end else if (rxBit_q == STOP_IDX) begin
                            rxBusy_q <= 1'b0;
                            rxStb_q  <= rxLine;
                            rxErr_q  <= !rxLine;
                        end else begin
                            rxSh_q <= {rxLine, rxSh_q[7:1]};
                        end
                    end
                end
            end
        end
    end

    // command parser: site byte, then request code
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_q <= ST_LISTEN;
        end else if (testMode) begin
            state_q <= ST_LISTEN;
        end else begin
            unique case (state_q)
                ST_LISTEN: begin
                    if (rxStb_q) begin
                        state_q <= (rxSh_q == siteNumber) ? ST_CODE
                                                          : ST_SKIP;
                    end
                end
                ST_SKIP: begin
                    if (rxStb_q || rxErr_q) begin
                        state_q <= ST_LISTEN;
                    end
                end
                ST_CODE: begin
                    if (rxErr_q) begin
                        state_q <= ST_LISTEN;
                    end else if (rxStb_q) begin
                        state_q <= ST_REPLY;
                    end
                end
                ST_REPLY: begin
                    if (txDone && curLast_q) begin
                        state_q <= ST_LISTEN;
                    end
                end
            endcase
        end
    end

    // hand the matched command to the user side
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            siteSeen_q <= 8'h00;
            cmdValid_q <= 1'b0;
            cmd_q      <= '0;
        end else begin
            cmdValid_q <= 1'b0;
            if (!testMode && rxStb_q && state_q == ST_LISTEN) begin
                siteSeen_q <= rxSh_q;
            end
            if (!testMode && rxStb_q && state_q == ST_CODE) begin
                cmdValid_q <= 1'b1;
                cmd_q      <= '{site: siteSeen_q, code: rxSh_q};
            end
        end
    end

    // reply window closes once the last character is queued
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            lastIn_q <= 1'b0;
        end else if (state_q != ST_REPLY) begin
            lastIn_q <= 1'b0;
        end else if (fifoInValid && fifoInReady && reply.last) begin
            lastIn_q <= 1'b1;
        end
    end

    // nothing enters the queue outside an open reply
    assign acceptOpen  = (state_q == ST_REPLY) && !lastIn_q;
    assign fifoInValid = replyValid && acceptOpen;
    assign replyReady  = fifoInReady && acceptOpen;

    asm_fifo #(
        .WIDTH ($bits(asm_reply_type)),
        .DEPTH (FIFO_DEPTH_P)
    ) u_fifo (
        .mclk     (mclk),
        .rstn     (rstn),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (reply),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOut)
    );

    // periodic test character; a new period wins over a take
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            testCnt_q  <= 32'h0000_0000;
            testPend_q <= 1'b0;
        end else if (!testMode) begin
            testCnt_q  <= 32'h0000_0000;
            testPend_q <= 1'b0;
        end else if (testCnt_q == TPER_M1) begin
            testCnt_q  <= 32'h0000_0000;
            testPend_q <= 1'b1;
        end else begin
            testCnt_q <= 32'(testCnt_q + 32'h0000_0001);
            if (testTake) begin
                testPend_q <= 1'b0;
            end
        end
    end

    // transmit source: test byte in test mode, else the reply queue
    assign testTake     = testMode && testPend_q && txReady
                          && !txSession_q;
    assign fifoOutReady = txReady && !testMode
                          && (state_q == ST_REPLY);
    assign fifoTake     = fifoOutValid && fifoOutReady;
    assign txStart      = testTake || fifoTake;
    assign txData       = testTake ? TEST_BYTE : fifoOut.data;

    asm_uart_tx #(
        .FRAME_BITS (FRAME_BITS),
        .OSR        (OVERSAMPLE)
    ) u_tx (
        .mclk       (mclk),
        .rstn       (rstn),
        .tick16     (tick16),
        .startValid (txStart),
        .startReady (txReady),
        .startData  (txData),
        .txd        (txd),
        .done       (txDone)
    );

    // driver on from first start bit until last stop bit is out;
    // held across gaps so the bus is not released mid reply
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            curLast_q   <= 1'b0;
            txSession_q <= 1'b0;
        end else begin
            if (txStart) begin
                curLast_q   <= testTake ? 1'b1 : fifoOut.last;
                txSession_q <= 1'b1;
            end else if (txDone && curLast_q) begin
                txSession_q <= 1'b0;
            end
        end
    end

    // loopback check in test mode
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            loopOk_q <= 1'b0;
        end else begin
            loopOk_q <= testMode && rxStb_q && (rxSh_q == TEST_BYTE);
        end
    end

    // one shifter feeds both ports, no selection
    assign rs232Tx    = txd;
    assign rs485TxOut = txd;
    assign rs485TxOe  = txSession_q;
    assign cmdValid   = cmdValid_q;
    assign cmd        = cmd_q;
    assign replyOpen  = acceptOpen;
    assign frameError = rxErr_q;
    assign loopOk     = loopOk_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_reply_only: assert property (
        txStart |-> (state_q == ST_REPLY) || testMode)
        else $error("transmit started without a command");
    a_site_match: assert property (
        rxStb_q && !testMode && state_q == ST_LISTEN
        && rxSh_q == siteNumber |=> state_q == ST_CODE)
        else $error("matching site not accepted");
    a_drv_cause: assert property (
        $rose(rs485TxOe) |-> $past(txStart))
        else $error("driver enabled without a transmission");
    a_half_duplex: assert property (
        rs485TxOe && !testMode && !$past(testMode) |-> !rxBusy_q)
        else $error("receiving while driving the bus");
    a_same_data: assert property (
        rs232Tx == rs485TxOut)
        else $error("ports carry different data");
    a_rx_merge: assert property (
        !sync485_q[1] || !sync232_q[1] |-> !rxLine)
        else $error("space on one port lost in merge");
    a_test_send: assert property (
        testTake |=> rs485TxOe && !rs485TxOut)
        else $error("test character not started");
    a_mismatch_drop: assert property (
        rxStb_q && !testMode && state_q == ST_LISTEN
        && rxSh_q != siteNumber |=> state_q == ST_SKIP && !rs485TxOe
        ##1 !cmdValid_q)
        else $error("mismatched command not dropped");
    a_oe_after_stop: assert property (
        txDone && curLast_q |=> !rs485TxOe)
        else $error("driver held after last stop bit");
    a_oe_drop_cause: assert property (
        $fell(rs485TxOe) |-> $past(txDone) && $past(rs485TxOut))
        else $error("driver released before stop bit done");

    c_command:   cover property (cmdValid_q);
    c_reply_end: cover property ($fell(rs485TxOe) && !testMode);
    c_mismatch:  cover property (state_q == ST_SKIP);
    c_loopback:  cover property (loopOk_q);
endmodule : asm_monitor_port

// File: asm_master_model.sv
`timescale 1ns/1ps

// remote master: speaks on either port, listens on the balanced pair
module asm_master_model #(
    parameter int BIT_CYC = 32
) (
    // clock
    input  logic mclk,
    // balanced pair, released driver leaves the bias at mark
    output logic drvEn,
    output logic drvLevel,
    input  logic busLevel,
    // unbalanced line towards the device, data only
    output logic line232
);
    logic [7:0] rxQ[$];
    logic [7:0] rxByte;
    int         k;

    initial begin
        drvEn    = 1'h0;
        drvLevel = 1'h1;
        line232  = 1'h1;
    end

    // one 8N1 character, lsb first; a bad stop is only for refusal tests
    task automatic send_byte(input logic [7:0] b, input bit on232,
                             input bit badStop);
        logic [9:0] fr;
        fr = {~badStop, b, 1'h0};
        @(negedge mclk);
        drvEn = !on232;
        for (int i = 0; i < 10; i++) begin
            if (on232)
                line232 = fr[i];
            else
                drvLevel = fr[i];
            repeat (BIT_CYC) @(negedge mclk);
        end
        drvEn   = 1'h0;
        line232 = 1'h1;
    endtask : send_byte

    // listen only while silent, so our own frames are never read back
    initial forever begin
        @(negedge mclk);
        if (!drvEn && busLevel === 1'h0) begin
            repeat (BIT_CYC / 2) @(negedge mclk);
            for (k = 0; k < 8; k++) begin
                repeat (BIT_CYC) @(negedge mclk);
                rxByte[k] = busLevel;
            end
            repeat (BIT_CYC) @(negedge mclk);
            rxQ.push_back(rxByte);
        end
    end
endmodule : asm_master_model

// File: tb_addressed_serial_monitor_port.sv
`timescale 1ns/1ps

module tb_addressed_serial_monitor_port;
    import asm_pkg::*;
    localparam int DIV     = 2;
    localparam int BIT_CYC = 16 * DIV;
    localparam int FRAME   = 10 * BIT_CYC;

    logic          mclk, rstn, rs232Rx, rs232Tx, rs485RxIn;
    logic          rs485TxOut, rs485TxOe, testMode, cmdValid;
    logic [7:0]    siteNumber, site, code;
    asm_cmd_type   cmd, lastCmd;
    asm_reply_type reply;
    logic          replyValid, replyReady, replyOpen, frameError, loopOk;
    logic          mDrvEn, mDrvLevel, m232, loopBack, grant, oePrev;
    int            n_errors, n_checks, nCmd, nFrameErr, nLoop, nStall;
    int            n0, t, seedVal;
    bit            on232, match;
    logic [7:0]    expQ[$];

    // bias holds the idle pair at mark; loop cable only in test mode
    assign rs485RxIn = rs485TxOe ? rs485TxOut : (mDrvEn ? mDrvLevel : 1'h1);
    assign rs232Rx   = loopBack ? rs232Tx : m232;

    asm_monitor_port #(
        .BAUD16_DIV_P (DIV),
        .TEST_PERIOD_P(600),
        .FIFO_DEPTH_P (4)
    ) u_dut (
        .mclk(mclk), .rstn(rstn), .rs232Rx(rs232Rx), .rs232Tx(rs232Tx),
        .rs485RxIn(rs485RxIn), .rs485TxOut(rs485TxOut),
        .rs485TxOe(rs485TxOe), .siteNumber(siteNumber),
        .testMode(testMode), .cmdValid(cmdValid), .cmd(cmd),
        .replyValid(replyValid), .replyReady(replyReady), .reply(reply),
        .replyOpen(replyOpen), .frameError(frameError), .loopOk(loopOk)
    );

    asm_master_model #(.BIT_CYC(BIT_CYC)) u_master (
        .mclk(mclk), .drvEn(mDrvEn), .drvLevel(mDrvLevel),
        .busLevel(rs485RxIn), .line232(m232)
    );

    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // expected command word and command count
    function automatic logic [15:0] exp_cmd(logic [7:0] s, logic [7:0] c);
        return {s, c};
    endfunction : exp_cmd

    function automatic int exp_count(int n, bit m);
        return m ? n + 1 : n;
    endfunction : exp_count

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    task automatic timeout_hit(string what);
        n_errors++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        final_report();
    endtask : timeout_hit

    // pulse counters and wire rules watched on every rising edge
    always @(posedge mclk) begin
        if (rstn) begin
            check("txSame", rs232Tx, rs485TxOut);
            check("busFree", rs485TxOe & mDrvEn, 1'h0);
            if (rs485TxOe === 1'h1 && oePrev !== 1'h1)
                check("oeGrant", grant, 1'h1);
            if (cmdValid === 1'h1 || testMode)
                grant = 1'h1;
            else if (oePrev === 1'h1 && rs485TxOe === 1'h0)
                grant = 1'h0;
            if (cmdValid === 1'h1) begin
                nCmd++;
                lastCmd = cmd;
            end
            if (frameError === 1'h1)
                nFrameErr++;
            if (loopOk === 1'h1)
                nLoop++;
            if (replyValid && replyReady !== 1'h1)
                nStall++;
            oePrev = rs485TxOe;
        end
    end

    // hand reply characters over, expect them back on the pair
    task automatic run_reply(input int n);
        asm_reply_type w;
        expQ.delete();
        u_master.rxQ.delete();
        check("replyOpen", replyOpen, 1'h1);
        for (int i = 0; i < n; i++) begin
            w.data = $urandom;
            w.last = (i == n - 1);
            expQ.push_back(w.data);
            @(negedge mclk);
            reply      = w;
            replyValid = 1'h1;
            t = 0;
            do begin
                @(posedge mclk);
                t++;
            end while (replyReady !== 1'h1 && t < 4 * FRAME);
            if (t >= 4 * FRAME)
                timeout_hit("replyReady");
        end
        @(negedge mclk);
        replyValid = 1'h0;
        check("replyClosed", replyOpen, 1'h0);
        for (t = 0; u_master.rxQ.size() < n; t++) begin
            if (t > (n + 2) * FRAME)
                timeout_hit("replyBytes");
            @(posedge mclk);
        end
        check("oeAtLastStop", rs485TxOe, 1'h1);
        for (t = 0; rs485TxOe !== 1'h0; t++) begin
            if (t > FRAME)
                timeout_hit("oeRelease");
            @(posedge mclk);
        end
        for (int i = 0; i < n; i++)
            check("replyByte", u_master.rxQ[i], expQ[i]);
    endtask : run_reply

    initial begin
        repeat (100000) @(posedge mclk);
        timeout_hit("watchdog");
    end

    initial begin
        seedVal    = $urandom(32'hCEE0B338);
        rstn       = 1'h0;
        testMode   = 1'h0;
        loopBack   = 1'h0;
        replyValid = 1'h0;
        reply      = '0;
        siteNumber = $urandom;
        repeat (16) @(negedge mclk);
        check("rstOe", rs485TxOe, 1'h0);
        check("rstTx", rs232Tx, 1'h1);
        check("rstReady", replyReady, 1'h0);
        rstn = 1'h1;
        repeat (4) @(negedge mclk);
        // port and match per command; a mismatch is followed at once
        for (int i = 0; i < 5; i++) begin
            on232 = (5'h06 >> i) & 1;
            match = (5'h15 >> i) & 1;
            n0    = nCmd;
            code  = $urandom;
            site  = match ? siteNumber : siteNumber ^ (8'h01 << ($urandom % 8));
            u_master.send_byte(site, on232, 0);
            u_master.send_byte(code, on232, 0);
            repeat (4) @(negedge mclk);
            check("cmdSeen", nCmd, exp_count(n0, match));
            if (match) begin
                check("cmdValue", lastCmd, exp_cmd(siteNumber, code));
                run_reply(i == 0 ? 6 : 1 + $urandom % 3);
            end else begin
                check("oeOff", rs485TxOe, 1'h0);
                check("noWindow", replyOpen, 1'h0);
            end
            $display("test command %0d done", i);
        end
        check("fifoRefused", nStall > 0, 1'h1);
        // broken stop bit is reported and dropped
        n0 = nFrameErr;
        u_master.send_byte($urandom, 0, 1);
        repeat (4) @(negedge mclk);
        check("frameErr", nFrameErr, exp_count(n0, 1'h1));
        repeat (FRAME) @(negedge mclk);
        $display("test frame error done");
        // loop cable fitted, device sends its test byte by itself
        n0       = nLoop;
        loopBack = 1'h1;
        testMode = 1'h1;
        for (t = 0; nLoop == n0; t++) begin
            if (t > 600 + 3 * FRAME)
                timeout_hit("loopOk");
            @(negedge mclk);
        end
        check("loopSeen", nLoop, n0 + 1);
        testMode = 1'h0;
        loopBack = 1'h0;
        repeat (2 * FRAME) @(negedge mclk);
        $display("test loopback done");
        final_report();
    end
endmodule : tb_addressed_serial_monitor_port
